/* File: design/adc_chain_framer.v */
`timescale 1ns/1ps
`include "adc_chain_framer_map.vh"

module adc_chain_framer (
	// System
	input  wire         sys_clk,
	input  wire         rst_n,
	// Wishbone slave
	input  wire         wb_cyc_i,
	input  wire         wb_stb_i,
	input  wire         wb_we_i,
	input  wire [7:0]   wb_adr_i,
	input  wire [3:0]   wb_sel_i,
	input  wire [31:0]  wb_dat_i,
	output reg  [31:0]  wb_dat_o,
	output reg          wb_ack_o,
	// Converter core results
	input  wire         sampleStrobe,
	input  wire [127:0] sampleResult,
	input  wire [63:0]  sampleHeader,
	// Format pins
	input  wire [1:0]   lane_format_select,
	// Serial link
	output reg          serial_bit_clock,
	output reg          frame_marker_n,
	output reg          serial_out_lane0,
	output reg          serial_out_lane1,
	input  wire         chain_in_lane_a,
	input  wire         chain_in_lane_b,
	// Synchronisation pins
	input  wire         start_n,
	input  wire         syncIn_n,
	output reg          syncOut_n
);

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
function [7:0] crcStep16;
	input [7:0]  crcIn;
	input [15:0] dataIn;
	integer      k;
	reg   [7:0]  c;
	reg          d;
	begin
		c = crcIn;
		for (k = 15; k >= 0; k = k - 1) begin
			d = dataIn[k];
			c = {c[6:2], d ^ c[7] ^ c[1], d ^ c[7] ^ c[0], d ^ c[7]};
		end
		crcStep16 = c;
	end
endfunction

function agreeEdgeFall;
	input [2:0] syncReg;
	input       held;
	begin
		agreeEdgeFall = held & ~syncReg[1] & ~syncReg[2];
	end
endfunction

// ----------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------
localparam [7:0] HALF_CYC = `BIT_HALF_CYC;
localparam [7:0] SYNC_CYC = `SYNC_OUT_CYC;

reg  [31:0]  control;
reg  [7:0]   divCnt;
reg          riseEn;
reg          fallEn;
reg  [2:0]   chainASync;
reg  [2:0]   chainBSync;
reg          chainAHeld;
reg          chainBHeld;
reg          chainABit;
reg          chainBBit;
reg  [2:0]   startSync;
reg          startHeld;
reg  [7:0]   syncOutCnt;
reg          syncInReg;
reg          syncInPrev;
reg          framePending;
reg  [4:0]   frameCount;
reg  [63:0]  crcReg;
reg  [191:0] frameWords;
reg  [191:0] shift0;
reg  [95:0]  shift1;
reg          loadRise;
reg          singleLane;
reg  [63:0]  next_crcReg;
reg  [63:0]  headerMux;
reg  [191:0] next_frameWords;
integer      ch;

wire         busReq    = wb_cyc_i & wb_stb_i;
wire         busWrite  = busReq & wb_we_i & wb_ack_o;
wire         serialMode = control[`CTL_SERIAL_MODE];
wire [1:0]   crcSel    = serialMode ?
	control[`CTL_CRC_SEL_HI:`CTL_CRC_SEL_LO] : `CRC_SEL_OFF;
wire [4:0]   groupLen  = (crcSel == `CRC_SEL_FOUR) ?
	`CRC_GROUP_FOUR : `CRC_GROUP_SIXTN;
wire         crcFrame  = (crcSel != `CRC_SEL_OFF) &&
	(frameCount == groupLen - 5'h01);
wire         syncCmd   = busWrite && wb_sel_i[1] && serialMode &&
	(wb_adr_i == `REG_CONTROL) && wb_dat_i[`CTL_SYNC_CMD];
wire         syncSeen  = ~syncInReg & syncInPrev;

// ----------------------------------------------------------------------
// Wishbone register file
// ----------------------------------------------------------------------
// A write lands on the edge where the master samples ack high, so it is
// taken exactly once and the very next read sees the new value.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
		control  <= `CONTROL_RESET;
	end else begin
		wb_ack_o <= busReq & ~wb_ack_o;
		if (busWrite && wb_adr_i == `REG_CONTROL) begin
			if (wb_sel_i[0])
				control[7:0] <= wb_dat_i[7:0] & 8'h07;
		end
		case (wb_adr_i)
		`REG_CONTROL:  wb_dat_o <= {24'h00_0000, control[7:0]};
		`REG_STATUS:   wb_dat_o <= {23'h00_0000, framePending,
			3'h0, frameCount};
		`REG_CRC_LOW:  wb_dat_o <= crcReg[31:0];
		`REG_CRC_HIGH: wb_dat_o <= crcReg[63:32];
		default:       wb_dat_o <= 32'h0000_0000;
		endcase
	end
end

// ----------------------------------------------------------------------
// Bit clock divider
// ----------------------------------------------------------------------
// The bit clock is generated here, so its edges are known one cycle ahead;
// the enables pulse in that cycle and outputs move with the edge itself.
always @(posedge sys_clk) begin
	if (!rst_n || syncSeen) begin
		divCnt           <= 8'h00;
		serial_bit_clock <= 1'b0;
		riseEn           <= 1'b0;
		fallEn           <= 1'b0;
	end else begin
		riseEn <= (divCnt == HALF_CYC - 8'h02);
		fallEn <= (divCnt == HALF_CYC + HALF_CYC - 8'h02);
		if (divCnt == HALF_CYC - 8'h01) begin
			serial_bit_clock <= 1'b1;
			divCnt           <= divCnt + 8'h01;
		end else if (divCnt == HALF_CYC + HALF_CYC - 8'h01) begin
			serial_bit_clock <= 1'b0;
			divCnt           <= 8'h00;
		end else begin
			divCnt <= divCnt + 8'h01;
		end
	end
end

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
// A pin level counts only once the second and third stages agree. That takes
// longer than half a bit period, so chain bits trail our own by two bits.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		chainASync <= 3'h0;
		chainBSync <= 3'h0;
		chainAHeld <= 1'b0;
		chainBHeld <= 1'b0;
		startSync  <= 3'h7;
		startHeld  <= 1'b1;
	end else begin
		chainASync <= {chainASync[1:0], chain_in_lane_a};
		chainBSync <= {chainBSync[1:0], chain_in_lane_b};
		startSync  <= {startSync[1:0], start_n};
		if (chainASync[1] == chainASync[2])
			chainAHeld <= chainASync[2];
		if (chainBSync[1] == chainBSync[2])
			chainBHeld <= chainBSync[2];
		if (startSync[1] == startSync[2])
			startHeld <= startSync[2];
	end
end

// Chain inputs are taken on the falling bit clock edge.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		chainABit <= 1'b0;
		chainBBit <= 1'b0;
	end else if (fallEn) begin
		chainABit <= chainAHeld;
		chainBBit <= chainBHeld;
	end
end

// ----------------------------------------------------------------------
// Synchronisation
// ----------------------------------------------------------------------
always @(posedge sys_clk) begin
	if (!rst_n) begin
		syncOutCnt <= 8'h00;
		syncOut_n  <= 1'b1;
	end else begin
		if (agreeEdgeFall(startSync, startHeld) || syncCmd) begin
			syncOutCnt <= SYNC_CYC;
			syncOut_n  <= 1'b0;
		end else if (syncOutCnt > 8'h01) begin
			syncOutCnt <= syncOutCnt - 8'h01;
		end else begin
			syncOutCnt <= 8'h00;
			syncOut_n  <= 1'b1;
		end
	end
end

// The sync input is treated as master-clock synchronous, so one register
// stage is enough; its falling level edge restarts framing and CRC.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		syncInReg  <= 1'b1;
		syncInPrev <= 1'b1;
	end else begin
		syncInReg  <= syncIn_n;
		syncInPrev <= syncInReg;
	end
end

// ----------------------------------------------------------------------
// Header and CRC per channel
// ----------------------------------------------------------------------
always @* begin
	next_crcReg     = crcReg;
	headerMux       = sampleHeader;
	next_frameWords = 192'h0;
	for (ch = 0; ch < `CHANNELS; ch = ch + 1) begin
		next_crcReg[ch*8 +: 8] = crcStep16(crcReg[ch*8 +: 8],
			sampleResult[ch*16 +: 16]);
		if (crcFrame) begin
			headerMux[ch*8 +: 8]   = next_crcReg[ch*8 +: 8];
			next_crcReg[ch*8 +: 8] = `CRC_INIT;
		end
		next_frameWords[(7 - ch)*24 +: 24] = {headerMux[ch*8 +: 8],
			sampleResult[ch*16 +: 16]};
	end
end

always @(posedge sys_clk) begin
	if (!rst_n || syncSeen) begin
		crcReg       <= {8{`CRC_INIT}};
		frameCount   <= 5'h00;
		framePending <= 1'b0;
		frameWords   <= 192'h0;
	end else begin
		if (sampleStrobe) begin
			crcReg       <= next_crcReg;
			frameWords   <= next_frameWords;
			framePending <= 1'b1;
			if (crcFrame || frameCount == `CRC_GROUP_SIXTN - 5'h01)
				frameCount <= 5'h00;
			else
				frameCount <= frameCount + 5'h01;
		end else if (riseEn && framePending) begin
			framePending <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------------
// Serial output and chain shift register
// ----------------------------------------------------------------------
// Own frame bits go out first and chain input bits enter at the tail, so the
// upstream frames follow ours in order, after two idle bits of synchroniser lag.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		shift0           <= 192'h0;
		shift1           <= 96'h0;
		singleLane       <= 1'b0;
		loadRise         <= 1'b0;
		frame_marker_n   <= 1'b1;
		serial_out_lane0 <= 1'b0;
		serial_out_lane1 <= 1'b0;
	end else if (riseEn) begin
		if (framePending) begin
			singleLane       <= lane_format_select[1];
			loadRise         <= 1'b1;
			frame_marker_n   <= 1'b0;
			serial_out_lane0 <= 1'b0;
			serial_out_lane1 <= 1'b0;
			if (lane_format_select[1]) begin
				shift0 <= frameWords;
				shift1 <= 96'h0;
			end else begin
				shift0 <= {frameWords[191:96], 96'h0};
				shift1 <= frameWords[95:0];
			end
		end else begin
			loadRise         <= 1'b0;
			frame_marker_n   <= 1'b1;
			serial_out_lane0 <= shift0[191];
			if (singleLane) begin
				shift0           <= {shift0[190:0], chainABit};
				serial_out_lane1 <= 1'b0;
			end else begin
				shift0 <= {shift0[190:96], chainABit, 96'h0};
				shift1 <= {shift1[94:0], chainBBit};
				serial_out_lane1 <= shift1[95];
			end
		end
	end
end

endmodule // adc_chain_framer

/* File: design/adc_chain_framer_map.vh */
`ifndef ADC_CHAIN_FRAMER_MAP_VH
`define ADC_CHAIN_FRAMER_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CONTROL      8'h00
`define REG_STATUS       8'h04
`define REG_CRC_LOW      8'h08
`define REG_CRC_HIGH     8'h0c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_SERIAL_MODE  0
`define CTL_CRC_SEL_LO   1
`define CTL_CRC_SEL_HI   2
`define CTL_SYNC_CMD     8
`define CONTROL_RESET    32'h0000_0000

// ----------------------------------------------------------------------
// CRC selection codes and constants
// ----------------------------------------------------------------------
`define CRC_SEL_OFF      2'h0
`define CRC_SEL_FOUR     2'h1
`define CRC_SEL_SIXTEEN  2'h2
`define CRC_INIT         8'hff
`define CRC_GROUP_FOUR   5'h04
`define CRC_GROUP_SIXTN  5'h10

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define CHANNELS         8
`define HEADER_BITS      8
`define RESULT_BITS      16
`define FRAME_BITS       24
`define LANE_BITS        192
`define HALF_LANE_BITS   96

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SYS_CLK_NS       5
`define BIT_HALF_NS      20
`define BIT_HALF_CYC     8'h04
`define SYNC_OUT_NS      20
`define SYNC_OUT_CYC     8'h04

`endif

/* File: verification/adc_chain_framer_assertions.sv */
`timescale 1ns/1ps
module adc_chain_framer_assertions (
	// System
	input wire	sys_clk,
	input wire	rst_n,
	// Bus handshake
	input wire	wb_cyc_i,
	input wire	wb_stb_i,
	input wire	wb_ack_o,
	// Serial link
	input wire	serial_bit_clock,
	input wire	frame_marker_n,
	input wire	serial_out_lane0,
	input wire	serial_out_lane1,
	// Synchronisation
	input wire	start_n,
	input wire	syncIn_n,
	input wire	syncOut_n
);
	// A sync pulse restarts the divider and the frame mid-phase, so the
	// link timing checks stand aside while it is low.
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_n || !syncIn_n);

	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
	a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
	property p_syncLow;
		disable iff (!rst_n)
		$fell(syncOut_n) |-> !syncOut_n [*4] ##1 syncOut_n;
	endproperty
	a_syncLow: assert property (p_syncLow) else $error("sync width");
	property p_start;
		disable iff (!rst_n)
		$fell(start_n) |-> ##[2:6] !syncOut_n;
	endproperty
	a_start: assert property (p_start) else $error("no sync out");
	property p_mark;
		$fell(frame_marker_n) |-> !frame_marker_n [*8] ##1 frame_marker_n;
	endproperty
	a_mark: assert property (p_mark) else $error("marker width");
	property p_launch;
		$changed({serial_out_lane1, serial_out_lane0, frame_marker_n})
			|-> $rose(serial_bit_clock);
	endproperty
	a_launch: assert property (p_launch) else $error("off-edge change");
	property p_bclkHi;
		$rose(serial_bit_clock) |-> serial_bit_clock [*4] ##1 !serial_bit_clock;
	endproperty
	a_bclkHi: assert property (p_bclkHi) else $error("bit clock high");
	property p_bclkLo; $fell(serial_bit_clock) |-> !serial_bit_clock [*4];
	endproperty
	a_bclkLo: assert property (p_bclkLo) else $error("bit clock low");
	property p_quiet;
		!frame_marker_n |-> !serial_out_lane0 && !serial_out_lane1;
	endproperty
	a_quiet: assert property (p_quiet) else $error("lane busy");
	c_sync: cover property ($fell(syncOut_n));
	c_frame: cover property ($rose(frame_marker_n));
	c_bus: cover property (wb_ack_o);
endmodule // adc_chain_framer_assertions

bind adc_chain_framer adc_chain_framer_assertions u_check (
	.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.serial_bit_clock(serial_bit_clock), .frame_marker_n(frame_marker_n),
	.serial_out_lane0(serial_out_lane0), .serial_out_lane1(serial_out_lane1),
	.start_n(start_n), .syncIn_n(syncIn_n), .syncOut_n(syncOut_n));

/* File: verification/chain_upstream_model.sv */
`timescale 1ns/1ps
module chain_upstream_model #(
	parameter logic [23:0] WORD_A = 24'h0,
	parameter logic [23:0] WORD_B = 24'h0
) (
	// Shared link
	input wire	sys_clk,
	input wire	bitClk,
	input wire	marker_n,
	// Chain lanes
	output logic	laneA = 1'b0,
	output logic	laneB = 1'b0
);
	logic	clkPrev = 1'b0;
	logic	markPrev = 1'b1;
	int	idx = 24;
	// Outside its word the lanes rest low, so the gap bits are known.
	always @(posedge sys_clk) begin
		clkPrev <= bitClk;
		if (bitClk && !clkPrev) begin
			markPrev <= marker_n;
			if (marker_n && !markPrev) begin
				laneA <= WORD_A[23];
				laneB <= WORD_B[23];
				idx <= 1;
			end else if (idx < 24) begin
				laneA <= WORD_A[23-idx];
				laneB <= WORD_B[23-idx];
				idx <= idx + 1;
			end else begin
				laneA <= 1'b0;
				laneB <= 1'b0;
			end
		end
	end
endmodule // chain_upstream_model

/* File: verification/test_adc_chain_sync_crc_output.sv */
`timescale 1ns/1ps
module test_adc_chain_sync_crc_output;
	localparam logic [23:0] UP_A = 24'h5ac3e1;
	localparam logic [23:0] UP_B = 24'h961f0b;
	logic		sys_clk = 0, rst_n = 0, sampleStrobe = 0, start_n = 1;
	logic		wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0]	wb_adr_i = 0;
	logic [3:0]	wb_sel_i = 4'hf;
	logic [31:0]	wb_dat_i = 0, wb_dat_o, q;
	logic [127:0]	sampleResult = 0;
	logic [63:0]	sampleHeader = 64'h8f7e6d5c4b3a2918;
	logic [1:0]	lane_format_select = 2'h2;
	logic		serial_bit_clock, frame_marker_n, syncOut_n;
	logic		serial_out_lane0, serial_out_lane1;
	logic		chain_in_lane_a, chain_in_lane_b;
	wire		syncIn_n = syncOut_n;
	logic [217:0]	got0, got1;
	logic [7:0]	crcs [8];
	int		miscompares = 0, samplesChecked = 0, cycles = 0;

	always #2.5 sys_clk = ~sys_clk;
	adc_chain_framer dut (.*);
	chain_upstream_model #(.WORD_A(UP_A), .WORD_B(UP_B)) up (
		.sys_clk(sys_clk), .bitClk(serial_bit_clock), .marker_n(frame_marker_n),
		.laneA(chain_in_lane_a), .laneB(chain_in_lane_b));

	// ----
	// Helpers
	// ----
	task test_done;
		$display("checked %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [217:0] g, e);
		samplesChecked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chkReg(input logic [31:0] g, e);
		chk({186'h0, g}, {186'h0, e});
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do @(posedge sys_clk); while (wb_ack_o !== 1 && n++ < 20);
		if (wb_ack_o !== 1) miscompares++;
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	task frame(input int nb);
		int n;
		got0 = 0;
		got1 = 0;
		@(posedge sys_clk);
		sampleStrobe <= 1;
		@(posedge sys_clk);
		sampleStrobe <= 0;
		n = 0;
		while (frame_marker_n !== 0 && n++ < 40) @(posedge sys_clk);
		while (frame_marker_n !== 1 && n++ < 80) @(posedge sys_clk);
		repeat (nb) begin
			@(negedge serial_bit_clock);
			got0 = {got0[216:0], serial_out_lane0};
			got1 = {got1[216:0], serial_out_lane1};
		end
	endtask
	// Upstream bits follow our own after two idle bits of synchroniser lag.
	function automatic logic [217:0] expv(input logic two, ln,
		input logic [63:0] h, input logic [127:0] r, input logic [23:0] u);
		logic [191:0] v;
		v = 0;
		for (int c = 0; c < (two ? 4 : 8); c++)
			v = {v[167:0], h[8*(c+4*ln)+:8], r[16*(c+4*ln)+:16]};
		return two ? {96'h0, v[95:0], 2'b00, u} : {v, 2'b00, u};
	endfunction

	// ----
	// Scenarios
	// ----
	task s_regs;
		logic [31:0] ev [5] = '{0, 0, 32'hffffffff, 32'hffffffff, 0};
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, 8'(4 * i), 0);
			chkReg(q, ev[i]);
		end
		wb(1'b1, 8'h10, 32'h5);
		wb(1'b0, 8'h10, 0);
		chkReg(q, 0);
	endtask
	task s_format;
		logic two;
		for (int f = 0; f < 4; f++) begin
			lane_format_select <= 2'(f);
			sampleResult <= {4{32'h3c5ae187 + 32'(f)}};
			two = f < 2;
			frame(two ? 122 : 218);
			chk(got0, expv(two, 0, sampleHeader, sampleResult, UP_A));
			if (two) chk(got1, expv(1, 1, sampleHeader, sampleResult, UP_B));
		end
	endtask
	task s_crc(input logic ser, input logic [1:0] sel, input int grp, nf);
		logic		fb;
		logic		rep;
		logic [63:0]	eh;
		lane_format_select <= 2'h2;
		wb(1'b1, 8'h00, {29'h0, sel, ser});
		if (ser) wb(1'b1, 8'h00, {23'h0, 1'b1, 5'h0, sel, ser});
		else repeat (2) begin
			start_n <= 0;
			repeat (10) @(posedge sys_clk);
			start_n <= 1;
			repeat (10) @(posedge sys_clk);
		end
		repeat (12) @(posedge sys_clk);
		wb(1'b0, 8'h04, 0);
		chkReg({27'h0, q[4:0]}, 0);
		wb(1'b0, 8'h0c, 0);
		chkReg(q, 32'hffffffff);
		for (int c = 0; c < 8; c++) crcs[c] = 8'hff;
		for (int f = 0; f < nf; f++) begin
			for (int c = 0; c < 8; c++)
				sampleResult[16*c+:16] <= (f == 1 && c == 2) ? 16'h0
					: 16'(16'h9e37 * (f + 1) + 16'h0f1d * c);
			frame(218);
			rep = ser && sel != 0 && f % grp == grp - 1;
			for (int c = 0; c < 8; c++) begin
				for (int b = 15; b >= 0; b--) begin
					fb = sampleResult[16*c+b] ^ crcs[c][7];
					crcs[c] = {crcs[c][6:2], crcs[c][1] ^ fb, crcs[c][0] ^ fb, fb};
				end
				eh[8*c+:8] = rep ? crcs[c] : sampleHeader[8*c+:8];
				if (rep) crcs[c] = 8'hff;
			end
			chk(got0, expv(0, 0, eh, sampleResult, UP_A));
		end
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1;
		s_regs;
		s_format;
		s_crc(1'b0, 2'h1, 4, 4);
		s_crc(1'b1, 2'h1, 4, 8);
		s_crc(1'b1, 2'h2, 16, 16);
		s_crc(1'b1, 2'h3, 16, 4);
		test_done;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			test_done;
		end
	end
endmodule // test_adc_chain_sync_crc_output
